// *** pkg/cac_consts.svh ***
/*
 * Holds the numeric constants of the calendar and alarm counter: register
 * indices, field positions, reset values and bus response codes.
 * Assumes it is included by its bare name wherever a number is needed.
 */
// Function
// - weekday register keeps a one-hot day in bits 6..0, bit 7 reads zero
// - each day advance rotates the weekday bit left, 40h wraps to 01h
// - date, month and year hold packed BCD, tens high, units low
// - date wraps to 01 after 31 or 30 depending on month
// - February in a normal year wraps after 28
// - February in a leap year wraps after 29
// - every year value divisible by four, 00 included, is leap
// - month steps January through December then back to January
// - year counts 00 to 99 then wraps to 00
// - alarm compares minute, hour and weekday or date with running time
// - alarm match sets the alarm flag and pulls the interrupt pin low
// - target select one compares date, zero compares one-hot weekday
// - alarm interrupt enable gates the pin; cleared keeps it released
// - external 24-hour counter wrap from 23 to 00 advances the day
`ifndef CAC_CONSTS_SVH
`define CAC_CONSTS_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define CAC_IDX_WEEKDAY 6'h03
`define CAC_IDX_DATE 6'h04
`define CAC_IDX_MONTH 6'h05
`define CAC_IDX_YEAR 6'h06
`define CAC_IDX_MIN_ALARM 6'h08
`define CAC_IDX_HOUR_ALARM 6'h09
`define CAC_IDX_WD_ALARM 6'h0A
`define CAC_IDX_CTRL 6'h10
`define CAC_IDX_STATUS 6'h11
`define CAC_IDX_MASK 6'h12

// ****************************************************************
// field positions and masks
// ****************************************************************
`define CAC_ALARM_FIELD_ENABLE_BIT 7
`define CAC_CTRL_TARGET_SELECT_BIT 0
`define CAC_CTRL_INT_ENABLE_BIT 1
`define CAC_ST_ALARM_BIT 0
`define CAC_ST_DAY_BIT 1
`define CAC_WEEKDAY_MASK 8'h7F
`define CAC_DATE_MASK 8'h3F
`define CAC_MONTH_MASK 8'h1F
`define CAC_CTRL_MASK 8'h03
`define CAC_STATUS_MASK 8'h03

// ****************************************************************
// calendar figures in BCD
// ****************************************************************
`define CAC_WEEKDAY_FIRST 8'h01
`define CAC_WEEKDAY_LAST 8'h40
`define CAC_DATE_FIRST 8'h01
`define CAC_DATE_LONG 8'h31
`define CAC_DATE_SHORT 8'h30
`define CAC_DATE_FEB_NORMAL 8'h28
`define CAC_DATE_FEB_LEAP 8'h29
`define CAC_MONTH_FIRST 8'h01
`define CAC_MONTH_FEB 8'h02
`define CAC_MONTH_APR 8'h04
`define CAC_MONTH_JUN 8'h06
`define CAC_MONTH_SEP 8'h09
`define CAC_MONTH_NOV 8'h11
`define CAC_MONTH_LAST 8'h12
`define CAC_YEAR_FIRST 8'h00
`define CAC_YEAR_LAST 8'h99

// ****************************************************************
// reset values
// ****************************************************************
`define CAC_RST_WEEKDAY 8'h01
`define CAC_RST_DATE 8'h01
`define CAC_RST_MONTH 8'h01
`define CAC_RST_YEAR 8'h00
`define CAC_RST_ALARM 8'h80
`define CAC_RST_CTRL 8'h00
`define CAC_RST_MASK 8'h00

// ****************************************************************
// AXI4-Lite responses
// ****************************************************************
`define CAC_RESP_OKAY 2'h0
`define CAC_RESP_SLVERR 2'h2

`endif

// *** pkg/cac_pkg.sv ***
/*
 * Types shared by the calendar and alarm counter modules.
 * Assumes the constants header is available for numeric values.
 */
package cac_pkg;

  // packed BCD byte, tens in the upper nibble
  typedef logic [7:0] cac_bcd_t;

  // write channel sequence, Gray coded
  typedef enum logic [1:0] {
    CAC_WR_COLLECT = 2'b00,
    CAC_WR_RESP = 2'b01
  } cac_wr_state_t;

endpackage

// *** pkg/cac_alarm_if.sv ***
/*
 * Carries the running time and alarm settings from the calendar top to the
 * alarm comparator, and the match event back.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface cac_alarm_if;
  import cac_pkg::*;
  cac_bcd_t minute;
  cac_bcd_t hour;
  cac_bcd_t weekday;
  cac_bcd_t date;
  cac_bcd_t minAlarm;
  cac_bcd_t hourAlarm;
  cac_bcd_t wdAlarm;
  logic targetSelect;
  logic matchRise;

  modport cal (
    output minute, hour, weekday, date, minAlarm, hourAlarm, wdAlarm, targetSelect,
    input matchRise
  );
  modport alm (
    input minute, hour, weekday, date, minAlarm, hourAlarm, wdAlarm, targetSelect,
    output matchRise
  );
endinterface

// *** rtl/cac_alarm.sv ***
/*
 * Alarm comparator: matches minute, hour and weekday or date against the
 * alarm settings and reports the start of a match as a one-cycle pulse.
 * Assumes the time values are stable BCD from the same clock domain.
 */
`timescale 1ns/1ps
`include "cac_consts.svh"
module cac_alarm
  import cac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  cac_alarm_if.alm alm
);

  logic minOk;
  logic hourOk;
  logic dayOk;
  logic matchNow;
  logic matchLast;

  // a field whose enable bit is set always agrees
  assign minOk = alm.minAlarm[`CAC_ALARM_FIELD_ENABLE_BIT] || (alm.minAlarm[6:0] == alm.minute[6:0]);
  assign hourOk = alm.hourAlarm[`CAC_ALARM_FIELD_ENABLE_BIT] || (alm.hourAlarm[5:0] == alm.hour[5:0]);

  // date compare or any weekday bit in common
  always_comb begin
    if (alm.wdAlarm[`CAC_ALARM_FIELD_ENABLE_BIT]) begin
      dayOk = 1'b1;
    end else if (alm.targetSelect) begin
      dayOk = (alm.wdAlarm[5:0] == alm.date[5:0]);
    end else begin
      dayOk = |(alm.wdAlarm[6:0] & alm.weekday[6:0]);
    end
  end

  assign matchNow = minOk && hourOk && dayOk;

  // only the start of a match counts, so a cleared flag stays clear for the rest of that minute
  always_ff @(posedge mclk) begin
    if (rst) begin
      matchLast <= 1'b1;
    end else begin
      matchLast <= matchNow;
    end
  end

  assign alm.matchRise = matchNow && !matchLast;

endmodule // cac_alarm

// *** rtl/cac_calendar.sv ***
/*
 * Calendar and alarm counter: weekday, date, month and year counters,
 * alarm registers, status with interrupt, all behind an AXI4-Lite slave.
 * Assumes dayCarry pulses for one cycle when the external 24-hour counter
 * wraps from 23 to 00, and that curMinute and curHour are BCD on mclk.
 */
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cac_consts.svh"
module cac_calendar
  import cac_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic dayCarry,
  input wire logic [7:0] curMinute,
  input wire logic [7:0] curHour,
  output logic irq,
  output logic alarmIntN
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  cac_wr_state_t wrState;
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0] wrData;
  logic wrLane;
  logic wrFire;
  logic [5:0] wrIdx;
  logic [5:0] rdIdx;
  logic wrHit;
  logic rdHit;
  logic [7:0] rdByte;
  cac_bcd_t weekday;
  cac_bcd_t date;
  cac_bcd_t month;
  cac_bcd_t year;
  cac_bcd_t minAlarm;
  cac_bcd_t hourAlarm;
  cac_bcd_t wdAlarm;
  logic [7:0] ctrl;
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] statusSet;
  logic [7:0] statusClr;
  logic leapYear;
  cac_bcd_t dateLast;
  logic dateWrap;
  logic monthWrap;
  logic [1:0] next_bresp;
  cac_alarm_if alarmBus ();

  // ****************************************************************
  // helpers
  // ****************************************************************

  // packed BCD increment, units carry into tens
  function automatic cac_bcd_t bcdInc(input cac_bcd_t v);
    cac_bcd_t r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // ****************************************************************
  // write channel
  // ****************************************************************

  // address and data are taken in either order and held until both are in
  assign awready = !awHeld && (wrState == CAC_WR_COLLECT);
  assign wready = !wHeld && (wrState == CAC_WR_COLLECT);
  assign wrFire = awHeld && wHeld && (wrState == CAC_WR_COLLECT);
  assign wrIdx = wrAddr[7:2];
  assign bvalid = (wrState == CAC_WR_RESP);

  always_ff @(posedge mclk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wrAddr <= '0;
    end else if (awvalid && awready) begin
      awHeld <= 1'b1;
      wrAddr <= awaddr;
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wHeld <= 1'b0;
      wrData <= 8'h00;
      wrLane <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld <= 1'b1;
      wrData <= wdata[7:0];
      wrLane <= wstrb[0];
    end else if (wrFire) begin
      wHeld <= 1'b0;
    end
  end

  // unmapped addresses answer with a slave error and store nothing
  always_comb begin
    if (wrIdx == `CAC_IDX_WEEKDAY || wrIdx == `CAC_IDX_DATE) begin
      wrHit = 1'b1;
    end else if (wrIdx == `CAC_IDX_MONTH || wrIdx == `CAC_IDX_YEAR) begin
      wrHit = 1'b1;
    end else if (wrIdx == `CAC_IDX_MIN_ALARM || wrIdx == `CAC_IDX_HOUR_ALARM) begin
      wrHit = 1'b1;
    end else if (wrIdx == `CAC_IDX_WD_ALARM || wrIdx == `CAC_IDX_CTRL) begin
      wrHit = 1'b1;
    end else if (wrIdx == `CAC_IDX_STATUS || wrIdx == `CAC_IDX_MASK) begin
      wrHit = 1'b1;
    end else begin
      wrHit = 1'b0;
    end
    next_bresp = wrHit ? `CAC_RESP_OKAY : `CAC_RESP_SLVERR;
  end

  // response waits for bready before the next write is accepted
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrState <= CAC_WR_COLLECT;
      bresp <= `CAC_RESP_OKAY;
    end else begin
      case (wrState)
        CAC_WR_COLLECT: begin
          if (wrFire) begin
            wrState <= CAC_WR_RESP;
            bresp <= next_bresp;
          end
        end
        CAC_WR_RESP: begin
          if (bready) begin
            wrState <= CAC_WR_COLLECT;
          end
        end
        default: begin
          wrState <= CAC_WR_COLLECT;
        end
      endcase
    end
  end

  // ****************************************************************
  // calendar counters
  // ****************************************************************

  // tens even: units 0,4,8; tens odd: units 2,6; 00 counts as leap
  assign leapYear = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                            : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);

  always_comb begin
    if (month == `CAC_MONTH_FEB) begin
      dateLast = leapYear ? `CAC_DATE_FEB_LEAP : `CAC_DATE_FEB_NORMAL;
    end else if (month == `CAC_MONTH_APR || month == `CAC_MONTH_JUN) begin
      dateLast = `CAC_DATE_SHORT;
    end else if (month == `CAC_MONTH_SEP || month == `CAC_MONTH_NOV) begin
      dateLast = `CAC_DATE_SHORT;
    end else begin
      dateLast = `CAC_DATE_LONG;
    end
  end

  // >= rather than == so a date written beyond month end still recovers
  assign dateWrap = (date >= dateLast);
  assign monthWrap = (month >= `CAC_MONTH_LAST);

  // a software write in the same cycle as a day advance wins for that register
  always_ff @(posedge mclk) begin
    if (rst) begin
      weekday <= `CAC_RST_WEEKDAY;
    end else if (wrFire && wrLane && wrIdx == `CAC_IDX_WEEKDAY) begin
      weekday <= wrData & `CAC_WEEKDAY_MASK;
    end else if (dayCarry) begin
      if (weekday[6:0] == `CAC_WEEKDAY_LAST) begin
        weekday <= `CAC_WEEKDAY_FIRST;
      end else begin
        weekday <= {1'b0, weekday[5:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      date <= `CAC_RST_DATE;
    end else if (wrFire && wrLane && wrIdx == `CAC_IDX_DATE) begin
      date <= wrData & `CAC_DATE_MASK;
    end else if (dayCarry) begin
      date <= dateWrap ? `CAC_DATE_FIRST : bcdInc(date);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      month <= `CAC_RST_MONTH;
    end else if (wrFire && wrLane && wrIdx == `CAC_IDX_MONTH) begin
      month <= wrData & `CAC_MONTH_MASK;
    end else if (dayCarry && dateWrap) begin
      month <= monthWrap ? `CAC_MONTH_FIRST : bcdInc(month);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      year <= `CAC_RST_YEAR;
    end else if (wrFire && wrLane && wrIdx == `CAC_IDX_YEAR) begin
      year <= wrData;
    end else if (dayCarry && dateWrap && monthWrap) begin
      year <= (year >= `CAC_YEAR_LAST) ? `CAC_YEAR_FIRST : bcdInc(year);
    end
  end

  // ****************************************************************
  // alarm and control registers
  // ****************************************************************

  // alarm registers keep every bit, spare bits act as plain storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      minAlarm <= `CAC_RST_ALARM;
      hourAlarm <= `CAC_RST_ALARM;
      wdAlarm <= `CAC_RST_ALARM;
    end else if (wrFire && wrLane) begin
      if (wrIdx == `CAC_IDX_MIN_ALARM) begin
        minAlarm <= wrData;
      end else if (wrIdx == `CAC_IDX_HOUR_ALARM) begin
        hourAlarm <= wrData;
      end else if (wrIdx == `CAC_IDX_WD_ALARM) begin
        wdAlarm <= wrData;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= `CAC_RST_CTRL;
      mask <= `CAC_RST_MASK;
    end else if (wrFire && wrLane) begin
      if (wrIdx == `CAC_IDX_CTRL) begin
        ctrl <= wrData & `CAC_CTRL_MASK;
      end else if (wrIdx == `CAC_IDX_MASK) begin
        mask <= wrData & `CAC_STATUS_MASK;
      end
    end
  end

  // ****************************************************************
  // alarm comparator
  // ****************************************************************
  assign alarmBus.minute = curMinute;
  assign alarmBus.hour = curHour;
  assign alarmBus.weekday = weekday;
  assign alarmBus.date = date;
  assign alarmBus.minAlarm = minAlarm;
  assign alarmBus.hourAlarm = hourAlarm;
  assign alarmBus.wdAlarm = wdAlarm;
  assign alarmBus.targetSelect = ctrl[`CAC_CTRL_TARGET_SELECT_BIT];

  cac_alarm alarmUnit (
    .mclk(mclk),
    .rst(rst),
    .alm(alarmBus)
  );

  // ****************************************************************
  // status and interrupts
  // ****************************************************************

  // events set, write one clears, and a set in the clearing cycle wins
  always_comb begin
    statusSet = 8'h00;
    statusSet[`CAC_ST_ALARM_BIT] = alarmBus.matchRise;
    statusSet[`CAC_ST_DAY_BIT] = dayCarry;
    statusClr = 8'h00;
    if (wrFire && wrLane && wrIdx == `CAC_IDX_STATUS) begin
      statusClr = wrData & `CAC_STATUS_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= 8'h00;
    end else begin
      status <= (status & ~statusClr) | statusSet;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
      alarmIntN <= 1'b1;
    end else begin
      irq <= |(status & mask);
      alarmIntN <= !(status[`CAC_ST_ALARM_BIT] && ctrl[`CAC_CTRL_INT_ENABLE_BIT]);
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  assign rdIdx = araddr[7:2];
  assign arready = !rvalid;

  // reserved bits are masked at store time except in the alarm registers, whose spare bits read back as written
  always_comb begin
    rdHit = 1'b1;
    if (rdIdx == `CAC_IDX_WEEKDAY) begin
      rdByte = weekday;
    end else if (rdIdx == `CAC_IDX_DATE) begin
      rdByte = date;
    end else if (rdIdx == `CAC_IDX_MONTH) begin
      rdByte = month;
    end else if (rdIdx == `CAC_IDX_YEAR) begin
      rdByte = year;
    end else if (rdIdx == `CAC_IDX_MIN_ALARM) begin
      rdByte = minAlarm;
    end else if (rdIdx == `CAC_IDX_HOUR_ALARM) begin
      rdByte = hourAlarm;
    end else if (rdIdx == `CAC_IDX_WD_ALARM) begin
      rdByte = wdAlarm;
    end else if (rdIdx == `CAC_IDX_CTRL) begin
      rdByte = ctrl;
    end else if (rdIdx == `CAC_IDX_STATUS) begin
      rdByte = status;
    end else if (rdIdx == `CAC_IDX_MASK) begin
      rdByte = mask;
    end else begin
      rdByte = 8'h00;
      rdHit = 1'b0;
    end
  end

  // one read at a time; data is held until rready
  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `CAC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rdByte};
      rresp <= rdHit ? `CAC_RESP_OKAY : `CAC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // cac_calendar

// *** verif/cac_calendar_chk.sv ***
/* port checker for the calendar top: bus answers, calendar read-back.
   assumes one clock, sync reset, bound from the testbench top file. */
`timescale 1ns/1ps
module cac_calendar_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic dayCarry,
  input wire logic [7:0] curMinute,
  input wire logic [7:0] curHour,
  input wire logic irq,
  input wire logic alarmIntN
);
  logic [ADDR_W-1:0] rAddr;
  // ****
  // read address kept so rdata can be judged by register
  // ****
  always_ff @(posedge mclk) begin
    if (rst) begin
      rAddr <= '0;
    end else if (arvalid && arready) begin
      rAddr <= araddr;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ****
  // properties
  // ****
  property p_aw_refuse; bvalid |-> !awready && !wready; endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while answer pending");
  property p_ar_refuse; rvalid |-> !arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while data pending");
  property p_rd_answer; arvalid && arready |=> rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_wr_answer; awvalid && awready && wvalid && wready |-> ##[1:3] bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_b_drop; bvalid && bready |=> !bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer not released");
  property p_r_drop; rvalid && rready |=> !rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer not released");
  property p_unmapped;
    rvalid && !(rAddr[7:2] inside {6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0A, 6'h10, 6'h11, 6'h12})
      |-> rresp == 2'h2;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_wd; rvalid && rAddr == 8'h0C |-> rdata[7] == 1'h0 && $onehot(rdata[6:0]); endproperty
  a_wd: assert property (p_wd) else $error("weekday not one-hot");
  property p_date; rvalid && rAddr == 8'h10 |-> rdata[7:6] == 2'h0 && rdata[3:0] <= 4'h9; endproperty
  a_date: assert property (p_date) else $error("date not BCD");
  property p_month;
    rvalid && rAddr == 8'h14 |-> rdata[7:0] inside {[8'h01:8'h09], [8'h10:8'h12]};
  endproperty
  a_month: assert property (p_month) else $error("month out of range");
  property p_year; rvalid && rAddr == 8'h18 |-> rdata[7:4] <= 4'h9 && rdata[3:0] <= 4'h9; endproperty
  a_year: assert property (p_year) else $error("year not BCD");
  c_sat: cover property (rvalid && rAddr == 8'h0C && rdata[7:0] == 8'h40);
  c_pin: cover property ($fell(alarmIntN));
  c_irq: cover property ($rose(irq));
endmodule // cac_calendar_chk

// *** verif/testbench.sv ***
/* self-checking bench for the calendar top over AXI4-Lite.
   assumes byte address is four times the register index. */
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, curMinute = 8'h00, curHour = 8'h00, rdD;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, dayCarry = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq, alarmIntN;
  logic [1:0] bresp, rresp, rsp;
  int errors = 0;
  int compares = 0;
  cac_calendar #(.ADDR_W(8)) cac_calendar_i (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'h1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(1'h1), .dayCarry(dayCarry), .curMinute(curMinute),
    .curHour(curHour), .irq(irq), .alarmIntN(alarmIntN));
  // clock and watchdog, the whole run needs a few hundred cycles
  always #2 mclk = ~mclk;
  initial begin
    #200000;
    errors++;
    summarize();
  end
  // ****
  // shared tasks; handshakes are judged at the falling edge before the taking edge
  // ****
  task automatic summarize;
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic ta, tw, dn;
    int n;
    n = 0;
    dn = 1'h0;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!dn) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      dn = bvalid;
      rsp = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      n++;
      if (n > 50) begin
        errors++;
        summarize();
      end
    end
  endtask
  task automatic rd(input logic [5:0] idx);
    logic ta, dn;
    int n;
    n = 0;
    dn = 1'h0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    while (!dn) begin
      @(negedge mclk);
      ta = arvalid && arready;
      dn = rvalid;
      rdD = rdata[7:0];
      rsp = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'h0;
      n++;
      if (n > 50) begin
        errors++;
        summarize();
      end
    end
  endtask
  task automatic rc(input logic [5:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(rdD, exp);
  endtask
  // one day advance, as the hour counter wrapping 23 to 00 would give
  task automatic adv;
    dayCarry <= 1'h1;
    @(posedge mclk);
    dayCarry <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    logic [5:0] ix [10] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0A, 6'h10, 6'h11, 6'h12};
    logic [7:0] ex [10] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) rc(ix[i], ex[i]);
    rd(6'h07);
    chk(rsp, 2'h2);
    wr(6'h07, 8'h55);
    chk(rsp, 2'h2);
  endtask
  task automatic t_weekday;
    wr(6'h11, 8'h03);
    wr(6'h12, 8'h02);
    wr(6'h03, 8'h01);
    for (int i = 1; i <= 8; i++) begin
      adv();
      rc(6'h03, 8'h01 << (i % 7));
    end
    chk(irq, 1'h1);
    rc(6'h11, 8'h02);
    wr(6'h11, 8'h02);
    settle();
    chk(irq, 1'h0);
    wr(6'h12, 8'h00);
  endtask
  task automatic t_calendar;
    // month, year, start date, then expected date, month, year
    logic [47:0] tb [10] = '{48'h012330_310123, 48'h012331_010223, 48'h042330_010523,
      48'h022328_010323, 48'h022428_290224, 48'h022429_010324, 48'h020028_290200,
      48'h129931_010100, 48'h122331_010124, 48'h091519_200915};
    for (int i = 0; i < 10; i++) begin
      wr(6'h06, tb[i][39:32]);
      wr(6'h05, tb[i][47:40]);
      wr(6'h04, tb[i][31:24]);
      adv();
      rc(6'h04, tb[i][23:16]);
      rc(6'h05, tb[i][15:8]);
      rc(6'h06, tb[i][7:0]);
    end
  endtask
  task automatic t_alarm;
    curHour <= 8'h12;
    wr(6'h04, 8'h15);
    wr(6'h08, 8'h30);
    wr(6'h09, 8'h12);
    wr(6'h0A, 8'h15);
    wr(6'h10, 8'h01);
    wr(6'h11, 8'h03);
    wr(6'h12, 8'h01);
    curMinute <= 8'h30;
    settle();
    chk(alarmIntN, 1'h1);
    chk(irq, 1'h1);
    rc(6'h11, 8'h01);
    wr(6'h11, 8'h01);
    settle();
    chk(irq, 1'h0);
    wr(6'h10, 8'h03);
    curMinute <= 8'h00;
    settle();
    curMinute <= 8'h30;
    settle();
    chk(alarmIntN, 1'h0);
    wr(6'h11, 8'h01);
    settle();
    chk(alarmIntN, 1'h1);
    // weekday target, minute left out of the match
    curHour <= 8'h00;
    wr(6'h03, 8'h08);
    wr(6'h0A, 8'h08);
    wr(6'h08, 8'h80);
    wr(6'h10, 8'h02);
    wr(6'h11, 8'h01);
    curHour <= 8'h12;
    settle();
    rc(6'h11, 8'h01);
    curHour <= 8'h00;
    wr(6'h0A, 8'h15);
    wr(6'h11, 8'h01);
    curHour <= 8'h12;
    settle();
    rc(6'h11, 8'h00);
    chk(alarmIntN, 1'h1);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    t_reset();
    t_weekday();
    t_calendar();
    t_alarm();
    summarize();
  end
endmodule // testbench
bind cac_calendar cac_calendar_chk #(.ADDR_W(ADDR_W)) chk_i (.mclk(mclk), .rst(rst), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .dayCarry(dayCarry),
  .curMinute(curMinute), .curHour(curHour), .irq(irq), .alarmIntN(alarmIntN));
